// *** src/nvm_access_pkg.sv ***
`default_nettype none
package nvm_access_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned OSC_KHZ = 8000;

  // I/O-space addresses (dedicated I/O instructions)
  localparam logic [7:0] ADDR_GP_STORE_0 = 8'h1E;
  localparam logic [7:0] ADDR_NVM_CTRL   = 8'h1F;
  localparam logic [7:0] ADDR_NVM_DATA   = 8'h20;
  localparam logic [7:0] ADDR_NVM_ADDR_L = 8'h21;
  localparam logic [7:0] ADDR_NVM_ADDR_H = 8'h22;
  localparam logic [7:0] ADDR_GP_STORE_1 = 8'h2A;
  localparam logic [7:0] ADDR_GP_STORE_2 = 8'h2B;
  localparam logic [7:0] IO_SPACE_LAST   = 8'h3F;
  localparam logic [7:0] BIT_SPACE_LAST  = 8'h1F;
  localparam logic [7:0] DATA_IO_OFFSET  = 8'h20;
  localparam logic [7:0] EXT_IO_FIRST    = 8'h60;

  // Control register fields
  localparam int unsigned CTRL_READ_STROBE   = 0;
  localparam int unsigned CTRL_PROG_ENABLE   = 1;
  localparam int unsigned CTRL_MASTER_ENABLE = 2;
  localparam int unsigned CTRL_READY_IRQ_EN  = 3;
  localparam int unsigned CTRL_MODE_LSB      = 4;

  localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
  localparam logic [1:0] MODE_ERASE_ONLY  = 2'h1;
  localparam logic [1:0] MODE_WRITE_ONLY  = 2'h2;
  localparam logic [1:0] MODE_RESERVED    = 2'h3;

  localparam logic [7:0] GP_STORE_RESET = 8'h00;

  // Programming times in microseconds, counted on the calibrated oscillator
  localparam int unsigned T_ERASE_WRITE_US = 3400;
  localparam int unsigned T_SINGLE_US      = 1800;
  localparam int unsigned OSC_ERASE_WRITE  = T_ERASE_WRITE_US * OSC_KHZ / 1000;
  localparam int unsigned OSC_SINGLE       = T_SINGLE_US * OSC_KHZ / 1000;

  localparam logic [2:0] MASTER_WINDOW = 3'h4;
  localparam logic [2:0] STALL_PROG    = 3'h2;
  localparam logic [2:0] STALL_READ    = 3'h4;
endpackage
`default_nettype wire

// *** src/nvm_prog_timer.sv ***
`default_nettype none
module nvm_prog_timer (
  input  wire logic        clock,
  input  wire logic        osc_tick,
  input  wire logic        start,
  input  wire logic [15:0] ticks,
  output logic             busy
);
  import nvm_access_pkg::*;

  // Power-up values only: a system reset must not touch a programming run under way
  logic [15:0] count_reg = 16'h0000;
  logic        busy_reg  = 1'b0;

  always_ff @(posedge clock) begin
    if (start) begin
      count_reg <= ticks;
    end else if (busy_reg && osc_tick) begin
      count_reg <= count_reg - 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (start) begin
      busy_reg <= 1'b1;
    end else if (busy_reg && osc_tick && count_reg <= 16'h0001) begin
      busy_reg <= 1'b0;
    end
  end

  assign busy = busy_reg;
endmodule
`default_nettype wire

// *** src/nvm_access_ctrl.sv ***
// Overview of operation
// - Address is high bit plus low byte
// - Unused address and control bits read zero
// - Data register sources writes, receives reads
// - Mode selects erase-write, erase, or write
// - Mode writes ignored while programming
// - Reset clears mode unless programming busy
// - Ready interrupt level while idle and enabled
// - Master enable self-clears after four cycles
// - Program enable without master does nothing
// - Program enable held until time elapses
// - Program start stalls CPU two cycles
// - Read strobe loads data immediately
// - Read stalls CPU four cycles
// - Busy refuses reads and address writes
// - Programming survives reset to completion
// - I/O and data-space address mapping
// - Bit instructions change only named bit
// - Extended I/O only through data space
// - Three general storage registers reset zero
// - Programming timed by calibrated oscillator
// - Unerased write-only leaves value lost
`default_nettype none
module nvm_access_ctrl (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       osc_tick,
  input  wire logic       io_space,
  input  wire logic [7:0] bus_addr,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  input  wire logic       bit_op,
  input  wire logic [2:0] bit_sel,
  input  wire logic       bit_val,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       global_irq_en,
  input  wire logic [7:0] array_rdata,
  output logic      [7:0] bus_rdata,
  output logic            cpu_stall,
  output logic            ready_irq,
  output logic      [8:0] array_addr,
  output logic      [7:0] array_wdata,
  output logic            array_start,
  output logic      [1:0] array_mode,
  output logic            array_rd
);
  import nvm_access_pkg::*;

  typedef enum logic [1:0] {
    IDLE = 2'b01,
    PROG = 2'b10
  } prog_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic [7:0] io_index(input logic sp, input logic [7:0] a);
    io_index = sp ? a : a - DATA_IO_OFFSET;
  endfunction

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic bop,
                                            input logic [2:0] sel, input logic val,
                                            input logic [7:0] wd);
    logic [7:0] r;
    r = old;
    if (bop) begin
      r[sel] = val;
    end else begin
      r = wd;
    end
    merge_byte = r;
  endfunction

  logic       in_range;
  logic [7:0] idx;
  logic       bit_ok;
  // Dedicated I/O instructions reach only 0x00-0x3F; extended space needs data access
  assign in_range = io_space ? (bus_addr <= IO_SPACE_LAST)
                             : (bus_addr >= DATA_IO_OFFSET && bus_addr < EXT_IO_FIRST);
  assign idx    = io_index(io_space, bus_addr);
  assign bit_ok = !bit_op || (io_space && bus_addr <= BIT_SPACE_LAST);

  logic wr_en;
  // Nothing is taken while reset is low, so no access can start a program under reset
  assign wr_en = nrst && bus_wr && in_range && bit_ok;

  logic wr_ctrl;
  logic wr_data;
  logic wr_al;
  logic wr_ah;
  logic wr_g0;
  logic wr_g1;
  logic wr_g2;
  assign wr_ctrl = wr_en && idx == ADDR_NVM_CTRL;
  assign wr_data = wr_en && idx == ADDR_NVM_DATA;
  assign wr_al   = wr_en && idx == ADDR_NVM_ADDR_L;
  assign wr_ah   = wr_en && idx == ADDR_NVM_ADDR_H;
  assign wr_g0   = wr_en && idx == ADDR_GP_STORE_0;
  assign wr_g1   = wr_en && idx == ADDR_GP_STORE_1;
  assign wr_g2   = wr_en && idx == ADDR_GP_STORE_2;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [1:0] mode_reg;
  logic       irq_en_reg;
  logic       master_reg;
  logic [2:0] master_cnt_reg;
  logic [8:0] nvm_addr;
  logic [7:0] nvm_data_reg;
  logic [7:0] gp_store_0;
  logic [7:0] gp_store_1;
  logic [7:0] gp_store_2;
  logic [2:0] stall_cnt_reg;
  logic       busy;
  prog_state_e state_reg;

  logic [7:0] ctrl_view;
  assign ctrl_view = {2'b00, mode_reg, irq_en_reg, master_reg, busy, 1'b0};

  logic [7:0] ctrl_new;
  assign ctrl_new = merge_byte(ctrl_view, bit_op, bit_sel, bit_val, bus_wdata);

  // Both strobes are refused while the timer runs
  logic pe_req;
  logic prog_go;
  logic rd_go;
  assign pe_req  = wr_ctrl && ctrl_new[CTRL_PROG_ENABLE] && !busy;
  // Reserved mode starts nothing and program enable stays clear
  assign prog_go = pe_req && master_reg && mode_reg != MODE_RESERVED;
  assign rd_go   = wr_ctrl && ctrl_new[CTRL_READ_STROBE] && !busy;

  logic [15:0] prog_ticks;
  assign prog_ticks = (mode_reg == MODE_ERASE_WRITE) ? 16'(OSC_ERASE_WRITE)
                                                     : 16'(OSC_SINGLE);

  nvm_prog_timer u_timer (
    .clock    (clock),
    .osc_tick (osc_tick),
    .start    (prog_go),
    .ticks    (prog_ticks),
    .busy     (busy)
  );

  // Mode survives reset while the array is still busy
  always_ff @(posedge clock) begin
    if (!nrst && !busy) begin
      mode_reg <= MODE_ERASE_WRITE;
    end else if (nrst && wr_ctrl && !busy) begin
      mode_reg <= ctrl_new[CTRL_MODE_LSB +: 2];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_en_reg <= 1'b0;
    end else if (wr_ctrl) begin
      irq_en_reg <= ctrl_new[CTRL_READY_IRQ_EN];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      master_reg     <= 1'b0;
      master_cnt_reg <= 3'h0;
    end else if (wr_ctrl && ctrl_new[CTRL_MASTER_ENABLE] && !master_reg) begin
      master_reg     <= 1'b1;
      master_cnt_reg <= MASTER_WINDOW;
    end else if (master_reg) begin
      master_cnt_reg <= master_cnt_reg - 3'h1;
      if (master_cnt_reg == 3'h1 || prog_go) begin
        master_reg <= 1'b0;
      end
    end
  end

  logic [7:0] addr_lo_new;
  logic [7:0] addr_hi_new;
  logic [8:0] nvm_addr_next;
  assign addr_lo_new = merge_byte(nvm_addr[7:0], bit_op, bit_sel, bit_val, bus_wdata);
  assign addr_hi_new = merge_byte({7'h00, nvm_addr[8]}, bit_op, bit_sel, bit_val, bus_wdata);

  always_comb begin
    nvm_addr_next = nvm_addr;
    if (!busy) begin
      if (wr_al) begin
        nvm_addr_next[7:0] = addr_lo_new;
      end
      if (wr_ah) begin
        nvm_addr_next[8] = addr_hi_new[0];
      end
    end
  end

  // Address has no reset value; software must set it before use
  always_ff @(posedge clock) begin
    nvm_addr <= nvm_addr_next;
  end

  always_ff @(posedge clock) begin
    if (rd_go) begin
      nvm_data_reg <= array_rdata;
    end else if (wr_data) begin
      nvm_data_reg <= merge_byte(nvm_data_reg, bit_op, bit_sel, bit_val, bus_wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      gp_store_0 <= GP_STORE_RESET;
    end else if (wr_g0) begin
      gp_store_0 <= merge_byte(gp_store_0, bit_op, bit_sel, bit_val, bus_wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      gp_store_1 <= GP_STORE_RESET;
    end else if (wr_g1) begin
      gp_store_1 <= merge_byte(gp_store_1, bit_op, bit_sel, bit_val, bus_wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      gp_store_2 <= GP_STORE_RESET;
    end else if (wr_g2) begin
      gp_store_2 <= merge_byte(gp_store_2, bit_op, bit_sel, bit_val, bus_wdata);
    end
  end

  // Follows the timer, so a reset during programming leaves it in PROG
  always_ff @(posedge clock) begin
    if (!nrst && !busy) begin
      state_reg <= IDLE;
    end else begin
      unique case (state_reg)
        IDLE: begin
          if (prog_go) begin
            state_reg <= PROG;
          end
        end
        PROG: begin
          if (!busy) begin
            state_reg <= IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU stall

  // A write that sets both strobe and enable stalls for the read
  always_ff @(posedge clock) begin
    if (!nrst) begin
      stall_cnt_reg <= 3'h0;
      cpu_stall     <= 1'b0;
    end else if (rd_go) begin
      stall_cnt_reg <= STALL_READ - 3'h1;
      cpu_stall     <= 1'b1;
    end else if (prog_go) begin
      stall_cnt_reg <= STALL_PROG - 3'h1;
      cpu_stall     <= 1'b1;
    end else if (stall_cnt_reg != 3'h0) begin
      stall_cnt_reg <= stall_cnt_reg - 3'h1;
    end else begin
      cpu_stall <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array side and read data

  always_ff @(posedge clock) begin
    if (!nrst) begin
      array_start <= 1'b0;
      array_rd    <= 1'b0;
    end else begin
      array_start <= prog_go;
      array_rd    <= rd_go;
    end
  end

  // Write-only over unerased cells is passed to the array as is; its result is undefined
  always_ff @(posedge clock) begin
    if (!nrst) begin
      array_mode <= MODE_ERASE_WRITE;
    end else if (prog_go) begin
      array_mode <= mode_reg;
    end
  end

  // Runs in step with the address register, so a strobe straight after an address write sees the new byte
  always_ff @(posedge clock) begin
    if (!nrst) begin
      array_addr  <= 9'h000;
      array_wdata <= 8'h00;
    end else begin
      array_addr  <= nvm_addr_next;
      array_wdata <= nvm_data_reg;
    end
  end

  // Level request; held low in the start cycle because busy shows only one edge later
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= irq_en_reg && global_irq_en && state_reg == IDLE && !busy && !prog_go;
    end
  end

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (bus_rd && in_range) begin
      unique case (idx)
        ADDR_GP_STORE_0: rd_mux = gp_store_0;
        ADDR_NVM_CTRL:   rd_mux = ctrl_view;
        ADDR_NVM_DATA:   rd_mux = nvm_data_reg;
        ADDR_NVM_ADDR_L: rd_mux = nvm_addr[7:0];
        ADDR_NVM_ADDR_H: rd_mux = {7'h00, nvm_addr[8]};
        ADDR_GP_STORE_1: rd_mux = gp_store_1;
        ADDR_GP_STORE_2: rd_mux = gp_store_2;
        default:         rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// *** dv/nvm_array_model.sv ***
`default_nettype none
module nvm_array_model (
  input  wire logic       clock,
  input  wire logic [8:0] array_addr,
  input  wire logic [7:0] array_wdata,
  input  wire logic       array_start,
  input  wire logic [1:0] array_mode,
  output logic      [7:0] array_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [512];
  initial for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'h5A;
  assign array_rdata = mem[array_addr];
  // Cells change at start; the bench never reads across a busy period, so the delay is not modelled
  always @(posedge clock) begin
    if (array_start === 1'h1) begin
      case (array_mode)
        2'h0: mem[array_addr] <= array_wdata;
        2'h1: mem[array_addr] <= 8'hFF;
        2'h2: mem[array_addr] <= mem[array_addr] & array_wdata;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** dv/nvm_access_ctrl_checker.sv ***
`default_nettype none
module nvm_access_ctrl_checker (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       io_space,
  input wire logic [7:0] bus_addr,
  input wire logic       bus_rd,
  input wire logic       global_irq_en,
  input wire logic [7:0] bus_rdata,
  input wire logic       cpu_stall,
  input wire logic       ready_irq,
  input wire logic       array_start,
  input wire logic [1:0] array_mode,
  input wire logic       array_rd
);
  import nvm_access_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_read_stall: assert property (array_rd |-> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read stall length wrong");
  chk_prog_stall: assert property (array_start |-> cpu_stall [*2] ##1 !cpu_stall)
    else $error("program stall length wrong");
  chk_no_reserved: assert property (array_start |-> array_mode != MODE_RESERVED)
    else $error("start with reserved mode");
  chk_irq_global: assert property (ready_irq |-> $past(global_irq_en))
    else $error("ready request without global enable");
  chk_irq_busy: assert property (array_start |-> ##2 !ready_irq [*8])
    else $error("ready request while busy");
  chk_stay_busy: assert property (array_start |=> !array_start [*8])
    else $error("second start while busy");
  chk_mode_hold: assert property (array_start |=> $stable(array_mode) [*8])
    else $error("mode changed while busy");
  chk_io_range: assert property (bus_rd && io_space && bus_addr > IO_SPACE_LAST |=> bus_rdata == 8'h00)
    else $error("read above io range not zero");
  chk_ext_io: assert property (bus_rd && !io_space && bus_addr >= EXT_IO_FIRST |=> bus_rdata == 8'h00)
    else $error("extended read not zero");
  chk_hi_zero: assert property (bus_rd && io_space && bus_addr == ADDR_NVM_ADDR_H |=> bus_rdata[7:1] == 7'h00)
    else $error("unused address bits not zero");
endmodule
bind nvm_access_ctrl nvm_access_ctrl_checker i_chk (.clock(clock), .nrst(nrst), .io_space(io_space),
  .bus_addr(bus_addr), .bus_rd(bus_rd), .global_irq_en(global_irq_en), .bus_rdata(bus_rdata), .cpu_stall(cpu_stall),
  .ready_irq(ready_irq), .array_start(array_start), .array_mode(array_mode), .array_rd(array_rd));
`default_nettype wire

// *** dv/eeprom_access_control_tb.sv ***
`default_nettype none
module eeprom_access_control_tb;
  import nvm_access_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic IO = 1'h1;
  localparam logic DS = 1'h0;
  logic       clock = 1'h0;
  logic       nrst = 1'h0;
  logic       io_space = 1'h1;
  logic [7:0] bus_addr = 8'h00;
  logic       bus_wr = 1'h0;
  logic       bus_rd = 1'h0;
  logic       bit_op = 1'h0;
  logic [2:0] bit_sel = 3'h0;
  logic       bit_val = 1'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic       global_irq_en = 1'h0;
  // Oscillator ticks every clock so the longest program fits the run budget
  logic       osc_tick = 1'h1;
  logic [7:0] array_rdata, bus_rdata, array_wdata, d;
  logic [8:0] array_addr;
  logic [1:0] array_mode;
  logic       cpu_stall, ready_irq, array_start, array_rd;
  logic [7:0] pmod [2] = '{8'h20, 8'h00};
  logic [7:0] pdat [2] = '{8'hC3, 8'h3C};
  int         error_cnt = 0;
  int         total_checks = 0;
  int         starts = 0;
  initial forever #4 clock = ~clock;
  nvm_access_ctrl i_dut (.clock(clock), .nrst(nrst), .osc_tick(osc_tick), .io_space(io_space), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bit_op(bit_op), .bit_sel(bit_sel), .bit_val(bit_val), .bus_wdata(bus_wdata),
    .global_irq_en(global_irq_en), .array_rdata(array_rdata), .bus_rdata(bus_rdata), .cpu_stall(cpu_stall),
    .ready_irq(ready_irq), .array_addr(array_addr), .array_wdata(array_wdata), .array_start(array_start),
    .array_mode(array_mode), .array_rd(array_rd));
  nvm_array_model i_mem (.clock(clock), .array_addr(array_addr), .array_wdata(array_wdata),
    .array_start(array_start), .array_mode(array_mode), .array_rdata(array_rdata));
  always @(posedge clock) if (array_start === 1'h1) starts <= starts + 1;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // A stalled CPU issues nothing, so every access waits the stall out first
  task automatic go;
    @(negedge clock);
    for (int i = 0; i < 8 && cpu_stall === 1'h1; i++) @(negedge clock);
    if (cpu_stall !== 1'h0) begin
      chk("stall ends", 8'h00, 8'h01);
      wrap_up();
    end
  endtask
  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] v, input logic bo = 1'h0);
    go();
    io_space = io;
    bus_addr = a;
    bus_wdata = v;
    bit_op = bo;
    bit_sel = v[2:0];
    bit_val = v[3];
    bus_wr = 1'h1;
    @(negedge clock);
    bus_wr = 1'h0;
    bit_op = 1'h0;
  endtask
  task automatic rc(input logic io, input logic [7:0] a, input logic [7:0] exp, input string what);
    go();
    io_space = io;
    bus_addr = a;
    bus_rd = 1'h1;
    @(negedge clock);
    bus_rd = 1'h0;
    d = bus_rdata;
    if (what != "") chk(what, exp, d);
  endtask
  task automatic wait_done;
    for (int i = 0; i < 20000; i++) begin
      rc(IO, ADDR_NVM_CTRL, 8'h00, "");
      if (d[CTRL_PROG_ENABLE] === 1'h0) return;
    end
    chk("program done", 8'h00, 8'h01);
    wrap_up();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clock);
    nrst = 1'h1;
    rc(IO, ADDR_GP_STORE_0, 8'h00, "gp0 reset");
    rc(IO, ADDR_GP_STORE_1, 8'h00, "gp1 reset");
    rc(IO, ADDR_GP_STORE_2, 8'h00, "gp2 reset");
    rc(IO, ADDR_NVM_CTRL, 8'h00, "ctrl reset");
    wr(IO, ADDR_GP_STORE_1, 8'h5A);
    rc(DS, ADDR_GP_STORE_1 + DATA_IO_OFFSET, 8'h5A, "gp1 data space");
    wr(DS, ADDR_GP_STORE_0 + DATA_IO_OFFSET, 8'hF1);
    wr(IO, ADDR_GP_STORE_0, 8'h0B, 1'h1);
    wr(IO, ADDR_GP_STORE_0, 8'h00, 1'h1);
    rc(IO, ADDR_GP_STORE_0, 8'hF8, "gp0 bit ops");
    wr(IO, ADDR_GP_STORE_1, 8'h08, 1'h1);
    rc(IO, ADDR_GP_STORE_1, 8'h5A, "bit op above range");
    wr(IO, ADDR_GP_STORE_2 + DATA_IO_OFFSET, 8'h77);
    rc(IO, ADDR_GP_STORE_2, 8'h00, "io write above range");
    rc(IO, ADDR_GP_STORE_2 + DATA_IO_OFFSET, 8'h00, "io read above range");
    rc(DS, EXT_IO_FIRST, 8'h00, "extended io");
    $display("test mapping done");
    wr(IO, ADDR_NVM_ADDR_H, 8'hFF);
    wr(IO, ADDR_NVM_ADDR_L, 8'h34);
    rc(IO, ADDR_NVM_ADDR_H, 8'h01, "addr high");
    wr(IO, ADDR_NVM_CTRL, 8'h01);
    rc(IO, ADDR_NVM_DATA, 8'h34 ^ 8'h5A, "read byte");
    chk("array addr high", 8'h01, {7'h00, array_addr[8]});
    rc(IO, ADDR_NVM_CTRL, 8'h00, "strobe reads zero");
    $display("test read done");
    wr(IO, ADDR_NVM_CTRL, 8'h02);
    rc(IO, ADDR_NVM_CTRL, 8'h00, "pe without master");
    wr(IO, ADDR_NVM_CTRL, 8'h04);
    repeat (3) @(negedge clock);
    wr(IO, ADDR_NVM_CTRL, 8'h02);
    chk("late pe", 8'h00, starts[7:0]);
    wr(IO, ADDR_NVM_CTRL, 8'h34);
    wr(IO, ADDR_NVM_CTRL, 8'h32);
    repeat (5) @(negedge clock);
    rc(IO, ADDR_NVM_CTRL, 8'h30, "reserved mode");
    global_irq_en = 1'h1;
    wr(IO, ADDR_NVM_CTRL, 8'h18);
    @(negedge clock);
    chk("irq idle", 8'h01, {7'h00, ready_irq});
    wr(IO, ADDR_NVM_CTRL, 8'h1C);
    wr(IO, ADDR_NVM_CTRL, 8'h1A);
    rc(IO, ADDR_NVM_CTRL, 8'h1A, "busy ctrl");
    chk("irq busy", 8'h00, {7'h00, ready_irq});
    wr(IO, ADDR_NVM_ADDR_L, 8'h00);
    wr(IO, ADDR_NVM_CTRL, 8'h28);
    rc(IO, ADDR_NVM_ADDR_L, 8'h34, "addr locked");
    rc(IO, ADDR_NVM_CTRL, 8'h1A, "mode locked");
    nrst = 1'h0;
    repeat (2) @(negedge clock);
    nrst = 1'h1;
    rc(IO, ADDR_NVM_CTRL, 8'h12, "reset while busy");
    wait_done();
    wr(IO, ADDR_NVM_CTRL, 8'h01);
    rc(IO, ADDR_NVM_DATA, 8'hFF, "erased byte");
    wr(IO, ADDR_NVM_CTRL, 8'h10);
    nrst = 1'h0;
    repeat (2) @(negedge clock);
    nrst = 1'h1;
    rc(IO, ADDR_NVM_CTRL, 8'h00, "mode reset");
    $display("test erase done");
    for (int k = 0; k < 2; k++) begin
      wr(IO, ADDR_NVM_DATA, pdat[k]);
      wr(IO, ADDR_NVM_CTRL, pmod[k] | 8'h04);
      wr(IO, ADDR_NVM_CTRL, pmod[k] | 8'h02);
      wait_done();
      wr(IO, ADDR_NVM_CTRL, 8'h01);
      rc(IO, ADDR_NVM_DATA, pdat[k], "programmed byte");
    end
    wr(IO, ADDR_NVM_CTRL, 8'h08);
    @(negedge clock);
    chk("irq enabled", 8'h01, {7'h00, ready_irq});
    global_irq_en = 1'h0;
    repeat (2) @(negedge clock);
    chk("irq global off", 8'h00, {7'h00, ready_irq});
    chk("start count", 8'h03, starts[7:0]);
    $display("test program done");
    wrap_up();
  end
endmodule
`default_nettype wire
